// [rdaa_pkg.sv]
// constants, types and coefficient table for the record-path block
// assumes one 20 MHz clock and a converter that tags each sample
`default_nettype none

package rdaa_pkg;

   // ***********************************
   // filter
   // ***********************************
   localparam int FIR_TAPS = 12;
   localparam int FIR_HALF = 6;
   localparam int COEF_W = 16;
   localparam int COEF_FRAC = 15;
   localparam logic [1:0] FAM_48K = 2'h0;
   localparam logic [1:0] FAM_96K = 2'h1;
   localparam logic [1:0] FAM_192K = 2'h2;

   // ***********************************
   // gain controller
   // ***********************************
   localparam int GAIN_W = 16;
   localparam int GAIN_FRAC = 12;
   localparam logic [15:0] GAIN_RST = 16'h1000;
   localparam logic [15:0] GAIN_STEP = 16'h0008;

   // ***********************************
   // activity detection
   // ***********************************
   localparam int ALERT_MODE_LSB = 6;
   localparam int CH_SEL_LSB = 4;
   localparam int VAD_SHIFT = 4;
   localparam int VAD_HOLD_W = 8;

   typedef enum logic [1:0] {
      RDAA_IDLE = 2'h0,
      RDAA_LISTEN = 2'h1,
      RDAA_RECORD = 2'h3
   } rdaa_state_t;

   typedef enum logic [1:0] {
      ALERT_IRQ = 2'h0,
      ALERT_WAKE = 2'h1,
      ALERT_BOTH = 2'h2,
      ALERT_RSVD = 2'h3
   } rdaa_alert_t;

   // symmetric half-band style taps, each half sums to 0.5 in Q15
   function automatic logic signed [15:0] coef(input logic [1:0] fam,
                                                input int k);
      int i;
      i = (k < FIR_HALF) ? k : FIR_TAPS - 1 - k;
      unique case (fam)
         FAM_96K: begin
            case (i)
               0: coef = -16'sd90;   1: coef = -16'sd410;
               2: coef = 16'sd350;   3: coef = 16'sd2150;
               4: coef = 16'sd6020;  default: coef = 16'sd8364;
            endcase
         end
         FAM_192K: begin
            case (i)
               0: coef = -16'sd60;   1: coef = -16'sd300;
               2: coef = 16'sd200;   3: coef = 16'sd2300;
               4: coef = 16'sd5900;  default: coef = 16'sd8344;
            endcase
         end
         default: begin
            case (i)
               0: coef = -16'sd120;  1: coef = -16'sd380;
               2: coef = 16'sd300;   3: coef = 16'sd2200;
               4: coef = 16'sd6000;  default: coef = 16'sd8384;
            endcase
         end
      endcase
   endfunction : coef

endpackage : rdaa_pkg

`default_nettype wire

// [rdaa_core.sv]
// record path: decimate-by-two filter, auto gain, voice activity watch
// assumes samples arrive at twice the output rate, tagged by channel,
// synchronous to core_clk_in; analog and digital mic samples look alike
`default_nettype none

module rdaa_core #(
   parameter int W = 24,
   parameter int VAD_HOLD = 8
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // converter samples
   input wire logic in_valid_in,
   input wire logic [1:0] in_chan_in,
   input wire logic signed [W-1:0] in_sample_in,
   input wire logic [1:0] rate_family_in,
   // recording control
   input wire logic record_start_in,
   input wire logic record_stop_in,
   // gain controller
   input wire logic agc_enable_in,
   input wire logic [15:0] manual_gain_in,
   input wire logic [W-1:0] agc_target_in,
   input wire logic [W-1:0] agc_noise_thresh_in,
   input wire logic [15:0] agc_max_gain_in,
   input wire logic [3:0] agc_attack_shift_in,
   input wire logic [3:0] agc_release_shift_in,
   // activity detection
   input wire logic voice_detect_enable_in,
   input wire logic [7:0] activity_cfg_in,
   input wire logic [W-1:0] vad_threshold_in,
   input wire logic vad_status_clear_in,
   // processed samples
   output logic out_valid_out,
   output logic [1:0] out_chan_out,
   output logic signed [W-1:0] out_sample_out,
   // status
   output logic alert_irq_out,
   output logic voice_detected_out,
   output logic low_power_out,
   output logic recording_out,
   output logic [15:0] gain_out
);

   localparam int ACCW = W + 24;
   localparam int NT = rdaa_pkg::FIR_TAPS;

   function automatic logic [W-1:0] mag(input logic signed [W-1:0] x);
      logic [W-1:0] m;
      m = x[W-1] ? W'(-x) : W'(x);
      // most negative code has no positive twin; clamp it
      mag = m[W-1] ? {1'b0, {(W-1){1'b1}}} : m;
   endfunction : mag

   function automatic logic signed [W-1:0] sat(
         input logic signed [ACCW-1:0] v);
      logic signed [ACCW-1:0] hi;
      logic signed [ACCW-1:0] lo;
      hi = ACCW'({1'b0, {(W-1){1'b1}}});
      lo = -hi - ACCW'(1);
      if (v > hi) sat = W'(hi);
      else if (v < lo) sat = W'(lo);
      else sat = W'(v);
   endfunction : sat

   // ***********************************
   // operating state
   // ***********************************
   rdaa_pkg::rdaa_state_t state;
   rdaa_pkg::rdaa_state_t next_state;
   rdaa_pkg::rdaa_alert_t alert_mode;
   logic detect;
   logic wake;

   assign alert_mode = rdaa_pkg::rdaa_alert_t'(
      activity_cfg_in[rdaa_pkg::ALERT_MODE_LSB +: 2]);
   assign wake = detect && (alert_mode == rdaa_pkg::ALERT_WAKE ||
                            alert_mode == rdaa_pkg::ALERT_BOTH);

   always_comb begin
      next_state = state;
      unique case (state)
         rdaa_pkg::RDAA_IDLE: begin
            if (record_start_in) next_state = rdaa_pkg::RDAA_RECORD;
            else if (voice_detect_enable_in)
               next_state = rdaa_pkg::RDAA_LISTEN;
         end
         rdaa_pkg::RDAA_LISTEN: begin
            if (record_start_in || wake)
               next_state = rdaa_pkg::RDAA_RECORD;
            else if (!voice_detect_enable_in)
               next_state = rdaa_pkg::RDAA_IDLE;
         end
         rdaa_pkg::RDAA_RECORD: begin
            if (record_stop_in)
               next_state = voice_detect_enable_in ?
                  rdaa_pkg::RDAA_LISTEN : rdaa_pkg::RDAA_IDLE;
         end
         default: next_state = rdaa_pkg::RDAA_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) state <= rdaa_pkg::RDAA_IDLE;
      else state <= next_state;
   end

   assign low_power_out = (state == rdaa_pkg::RDAA_LISTEN);
   assign recording_out = (state == rdaa_pkg::RDAA_RECORD);

   // ***********************************
   // decimation filter
   // ***********************************
   // per-channel history; only runs while recording to save power
   logic signed [W-1:0] dline [4][NT-1];
   logic [3:0] phase;
   logic take;
   logic signed [ACCW-1:0] acc;
   logic filt_valid;
   logic [1:0] filt_chan;
   logic signed [W-1:0] filt_data;

   assign take = in_valid_in && recording_out;

   // taps per rate family shape ripple and stopband; delay is the same for all
   always_comb begin
      logic signed [W-1:0] x;
      x = '0;
      // newest sample sits on tap 0, history on the rest
      acc = ACCW'(in_sample_in) * ACCW'(rdaa_pkg::coef(rate_family_in, 0));
      for (int k = 1; k < NT; k++) begin
         x = dline[in_chan_in][k-1];
         acc = acc + ACCW'(x) *
               ACCW'(rdaa_pkg::coef(rate_family_in, k));
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int c = 0; c < 4; c++)
            for (int k = 0; k < NT - 1; k++)
               dline[c][k] <= '0;
      end else if (take) begin
         dline[in_chan_in][0] <= in_sample_in;
         for (int k = 1; k < NT - 1; k++)
            dline[in_chan_in][k] <= dline[in_chan_in][k-1];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) phase <= 4'h0;
      else if (!recording_out) phase <= 4'h0;
      else if (take) phase[in_chan_in] <= ~phase[in_chan_in];
   end

   // short symmetric kernel keeps delay under three output periods
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         filt_valid <= 1'b0;
         filt_chan <= 2'h0;
         filt_data <= '0;
      end else begin
         filt_valid <= take && phase[in_chan_in];
         if (take && phase[in_chan_in]) begin
            filt_chan <= in_chan_in;
            filt_data <= sat(acc >>> rdaa_pkg::COEF_FRAC);
         end
      end
   end

   // ***********************************
   // auto gain controller
   // ***********************************
   logic [W-1:0] env;
   logic [W-1:0] fmag;
   logic [15:0] gain;

   assign fmag = mag(filt_data);
   assign gain_out = gain;

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) env <= '0;
      else if (filt_valid) begin
         if (fmag > env)
            env <= env + ((fmag - env) >> agc_attack_shift_in);
         else
            env <= env - ((env - fmag) >> agc_release_shift_in);
      end
   end

   // noise floor freezes gain so hiss is not pumped up
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) gain <= rdaa_pkg::GAIN_RST;
      else if (!agc_enable_in) gain <= manual_gain_in;
      else if (gain > agc_max_gain_in) gain <= agc_max_gain_in;
      else if (filt_valid && env >= agc_noise_thresh_in) begin
         if (env > agc_target_in && gain > rdaa_pkg::GAIN_STEP)
            gain <= gain - rdaa_pkg::GAIN_STEP;
         else if (env < agc_target_in &&
                  agc_max_gain_in - gain >= rdaa_pkg::GAIN_STEP)
            gain <= gain + rdaa_pkg::GAIN_STEP;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         out_valid_out <= 1'b0;
         out_chan_out <= 2'h0;
         out_sample_out <= '0;
      end else begin
         out_valid_out <= filt_valid;
         if (filt_valid) begin
            out_chan_out <= filt_chan;
            out_sample_out <= sat((ACCW'(filt_data) *
               ACCW'(signed'({1'b0, gain}))) >>> rdaa_pkg::GAIN_FRAC);
         end
      end
   end

   // ***********************************
   // voice activity detector
   // ***********************************
   logic [W-1:0] energy;
   logic [rdaa_pkg::VAD_HOLD_W-1:0] hold;
   logic watch;

   // raw samples, so either mic type feeds it the same way
   assign watch = low_power_out && in_valid_in &&
      in_chan_in == activity_cfg_in[rdaa_pkg::CH_SEL_LSB +: 2];
   assign detect = watch && energy > vad_threshold_in &&
      hold == rdaa_pkg::VAD_HOLD_W'(VAD_HOLD - 1);

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) energy <= '0;
      else if (!low_power_out) energy <= '0;
      else if (watch)
         energy <= energy + (mag(in_sample_in) >> rdaa_pkg::VAD_SHIFT)
                  - (energy >> rdaa_pkg::VAD_SHIFT);
   end

   // run-length filter rejects single clicks
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) hold <= '0;
      else if (!low_power_out) hold <= '0;
      else if (watch) begin
         if (energy <= vad_threshold_in) hold <= '0;
         else if (hold != rdaa_pkg::VAD_HOLD_W'(VAD_HOLD - 1))
            hold <= hold + 1'b1;
      end
   end

   // a new event beats a clear in the same cycle
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) voice_detected_out <= 1'b0;
      else if (detect) voice_detected_out <= 1'b1;
      else if (vad_status_clear_in) voice_detected_out <= 1'b0;
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) alert_irq_out <= 1'b0;
      else alert_irq_out <= detect &&
         alert_mode != rdaa_pkg::ALERT_WAKE;
   end

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_odd_in;
      take && phase[in_chan_in];
   endsequence

   sequence s_to_out;
      filt_valid ##1 out_valid_out;
   endsequence

   a_decim_output: assert property (s_odd_in |=> s_to_out)
      else $error("odd sample did not produce an output");
   a_even_silent: assert property (
      take && !phase[in_chan_in] |=> !filt_valid)
      else $error("even sample produced an output");
   a_enter_listen: assert property (
      state == rdaa_pkg::RDAA_IDLE && voice_detect_enable_in &&
      !record_start_in |=> low_power_out)
      else $error("enable did not enter low power watch");
   a_wake_record: assert property (
      low_power_out && wake |=> recording_out)
      else $error("wake mode did not start recording");
   a_irq_pulse: assert property (
      detect && alert_mode != rdaa_pkg::ALERT_WAKE |=> alert_irq_out)
      else $error("irq mode gave no alert");
   a_irq_cause: assert property (
      alert_irq_out |-> voice_detected_out)
      else $error("alert without latched status");
   a_set_wins: assert property (
      detect && vad_status_clear_in |=> voice_detected_out)
      else $error("clear beat a new event");
   a_one_chan: assert property (
      detect |-> in_chan_in == activity_cfg_in[rdaa_pkg::CH_SEL_LSB +: 2])
      else $error("detection on unselected channel");
   // ceiling only judged while the host leaves it alone for the cycle
   a_gain_limit: assert property (
      (agc_enable_in && gain <= agc_max_gain_in) ##1
      $stable(agc_max_gain_in) |-> gain <= agc_max_gain_in)
      else $error("gain passed its ceiling");
   a_gain_raise: assert property (
      agc_enable_in && filt_valid && env >= agc_noise_thresh_in &&
      agc_max_gain_in >= rdaa_pkg::GAIN_STEP &&
      env < agc_target_in && gain <= agc_max_gain_in - rdaa_pkg::GAIN_STEP
      |=> gain == $past(gain) + rdaa_pkg::GAIN_STEP)
      else $error("weak input did not raise gain");
   a_no_watch_rec: assert property (
      recording_out |-> !watch ##1 energy == '0)
      else $error("detector ran outside low power watch");

endmodule : rdaa_core

`default_nettype wire

// [rdaa_host_model.sv]
// host-side model: sets up activity detection and the gain target
// assumes the core's clock and reset; drives just after rising edges
`default_nettype none

module rdaa_host_model (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // status from the core
   input wire logic alert_irq_in,
   input wire logic voice_detected_in,
   // configuration to the core
   output var logic voice_detect_enable_out,
   output var logic [7:0] activity_cfg_out,
   output var logic vad_status_clear_out,
   output var logic [23:0] agc_target_out
);
   timeunit 1ns;
   timeprecision 1ps;

   int alerts = 0;

   initial begin
      voice_detect_enable_out = 1'b0;
      activity_cfg_out = 8'h00;
      vad_status_clear_out = 1'b0;
      // one-sixteenth scale leaves headroom for loud bursts
      agc_target_out = 24'h080000;
   end

   // alert is one cycle wide, so count it at every edge
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         alerts <= 0;
      end else if (alert_irq_in === 1'b1) begin
         alerts <= alerts + 1;
      end
   end

   task automatic arm(input logic [1:0] mode, input logic [1:0] ch);
      @(posedge core_clk_in);
      #2;
      activity_cfg_out = {mode, ch, 4'h0};
      voice_detect_enable_out = 1'b1;
   endtask : arm

   // reading the latched cause clears it
   task automatic disarm();
      @(posedge core_clk_in);
      #2;
      voice_detect_enable_out = 1'b0;
      vad_status_clear_out = voice_detected_in;
      @(posedge core_clk_in);
      #2;
      vad_status_clear_out = 1'b0;
   endtask : disarm
endmodule : rdaa_host_model

`default_nettype wire

// [record_decimation_agc_activity_bench.sv]
// bench for the record-path core: filter, gain and activity scenarios
// assumes rdaa_pkg, rdaa_core and rdaa_host_model compiled before it
`default_nettype none

module record_decimation_agc_activity_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk_in, rst_b_in, in_valid_in, record_start_in;
   logic record_stop_in, agc_enable_in, voice_detect_enable;
   logic vad_status_clear, out_valid_out, alert_irq_out;
   logic voice_detected_out, low_power_out, recording_out;
   logic [1:0] in_chan_in, rate_family_in, out_chan_out;
   logic [3:0] attack, release_sh;
   logic [7:0] activity_cfg;
   logic [15:0] manual_gain_in, agc_max_gain_in, gain_out;
   logic [23:0] in_sample_in, out_sample_out, agc_target;
   logic [23:0] agc_noise_thresh_in, vad_threshold_in;
   int errors = 0;
   int checks_done = 0;
   int n_out = 0;

   rdaa_core #(.W(24), .VAD_HOLD(2)) dut (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .in_valid_in(in_valid_in), .in_chan_in(in_chan_in),
      .in_sample_in(in_sample_in), .rate_family_in(rate_family_in),
      .record_start_in(record_start_in), .record_stop_in(record_stop_in),
      .agc_enable_in(agc_enable_in), .manual_gain_in(manual_gain_in),
      .agc_target_in(agc_target), .agc_noise_thresh_in(agc_noise_thresh_in),
      .agc_max_gain_in(agc_max_gain_in), .agc_attack_shift_in(attack),
      .agc_release_shift_in(release_sh),
      .voice_detect_enable_in(voice_detect_enable),
      .activity_cfg_in(activity_cfg), .vad_threshold_in(vad_threshold_in),
      .vad_status_clear_in(vad_status_clear),
      .out_valid_out(out_valid_out), .out_chan_out(out_chan_out),
      .out_sample_out(out_sample_out), .alert_irq_out(alert_irq_out),
      .voice_detected_out(voice_detected_out),
      .low_power_out(low_power_out), .recording_out(recording_out),
      .gain_out(gain_out));

   rdaa_host_model host (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .alert_irq_in(alert_irq_out), .voice_detected_in(voice_detected_out),
      .voice_detect_enable_out(voice_detect_enable),
      .activity_cfg_out(activity_cfg),
      .vad_status_clear_out(vad_status_clear), .agc_target_out(agc_target));

   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in) begin
      if (out_valid_out === 1'b1) begin
         n_out <= n_out + 1;
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: flag %b not %b", $time, got, exp);
      end
   endtask : check_bit

   task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
      end
   endtask : check_word

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #2;
   endtask : tick

   // strobe stays up across the run so it is never lowered and raised at once
   task automatic burst(input logic [1:0] ch, input logic [23:0] v, int n);
      in_chan_in = ch;
      in_sample_in = v;
      in_valid_in = 1'b1;
      tick(n);
      in_valid_in = 1'b0;
   endtask : burst

   task automatic record_cmd(input logic start);
      record_start_in = start;
      record_stop_in = ~start;
      tick(1);
      record_start_in = 1'b0;
      record_stop_in = 1'b0;
   endtask : record_cmd

   task automatic test_filter(input logic [1:0] fam);
      int n0;
      rate_family_in = fam;
      manual_gain_in = (fam == 2'h1) ? 16'h2000 : 16'h1000;
      record_cmd(1'b1);
      check_bit(recording_out, 1'b1);
      burst(2'h0, 24'h001000, 12);
      tick(3);
      burst(2'h0, 24'h001000, 2);
      check_bit(out_valid_out, 1'b0);
      tick(1);
      check_bit(out_valid_out, 1'b1);
      // taps sum to unity, so a settled constant passes times the gain
      check_word(out_sample_out, {fam == 2'h1, 1'b0} == 2'h2 ? 24'h002000
                 : 24'h001000);
      record_cmd(1'b0);
      n0 = n_out;
      burst(2'h0, 24'h001000, 4);
      tick(4);
      check_bit(n_out == n0, 1'b1);
      $display("filter test done, family %0d", fam);
   endtask : test_filter

   task automatic test_agc();
      logic [15:0] g0;
      agc_enable_in = 1'b1;
      record_cmd(1'b1);
      burst(2'h1, 24'h400000, 40);
      tick(3);
      check_bit(gain_out < 16'h1000, 1'b1);
      g0 = gain_out;
      agc_noise_thresh_in = 24'hFFFFFF;
      burst(2'h1, 24'h400000, 8);
      tick(3);
      check_word({8'h00, gain_out}, {8'h00, g0});
      agc_noise_thresh_in = 24'h000000;
      agc_max_gain_in = 16'h0800;
      tick(2);
      check_bit(gain_out <= 16'h0800, 1'b1);
      // quiet input drains the envelope below target, then gain climbs
      agc_max_gain_in = 16'h1FFF;
      burst(2'h1, 24'h000000, 128);
      check_bit(gain_out > 16'h0800, 1'b1);
      agc_enable_in = 1'b0;
      tick(2);
      check_word({8'h00, gain_out}, {8'h00, manual_gain_in});
      record_cmd(1'b0);
      $display("gain test done");
   endtask : test_agc

   task automatic test_vad(input logic [1:0] mode, input logic [1:0] ch);
      int a0;
      int i;
      host.arm(mode, ch);
      tick(1);
      check_bit(low_power_out, 1'b1);
      burst(ch + 2'h1, 24'h100000, 12);
      tick(2);
      check_bit(voice_detected_out, 1'b0);
      a0 = host.alerts;
      i = 0;
      while (i < 40 && voice_detected_out !== 1'b1) begin
         burst(ch, 24'h100000, 1);
         tick(1);
         i++;
      end
      if (i == 40) begin
         errors++;
         report_and_stop();
      end
      tick(1);
      check_bit(host.alerts == a0 + (mode == 2'h1 ? 0 : 1), 1'b1);
      check_bit(recording_out, mode == 2'h1 || mode == 2'h2);
      check_bit(voice_detected_out, 1'b1);
      host.disarm();
      record_cmd(1'b0);
      check_bit(voice_detected_out, 1'b0);
      check_bit(low_power_out, 1'b0);
      $display("activity test done, mode %0d", mode);
   endtask : test_vad

   // hang guard
   initial begin
      repeat (50000) @(posedge core_clk_in);
      errors++;
      report_and_stop();
   end

   initial begin
      rst_b_in = 1'b0;
      in_valid_in = 1'b0;
      in_chan_in = 2'h0;
      in_sample_in = 24'h000000;
      rate_family_in = 2'h0;
      record_start_in = 1'b0;
      record_stop_in = 1'b0;
      agc_enable_in = 1'b0;
      manual_gain_in = 16'h1000;
      agc_max_gain_in = 16'h1FFF;
      agc_noise_thresh_in = 24'h000000;
      attack = 4'h2;
      release_sh = 4'h3;
      vad_threshold_in = 24'h000100;
      repeat (12) @(posedge core_clk_in);
      check_word({8'h00, gain_out}, 24'h001000);
      check_bit(recording_out, 1'b0);
      #2;
      rst_b_in = 1'b1;
      tick(1);
      for (int f = 0; f < 3; f++) begin
         test_filter(f[1:0]);
      end
      test_agc();
      for (int m = 0; m < 4; m++) begin
         test_vad(m[1:0], m[1:0]);
      end
      report_and_stop();
   end
endmodule : record_decimation_agc_activity_bench

`default_nettype wire
